// >>> design/pmvd_regs.svh
// Purpose: Register offsets, field positions, reset values and timing for the power/voltage block
// Assumes: Byte-wide register file reached by register number
// Notes:   Definitions only
`ifndef PMVD_REGS_SVH
`define PMVD_REGS_SVH

// Register numbers
`define PMVD_ADDR_SRC_CTRL    8'h0b
`define PMVD_ADDR_VDET        8'h0c
`define PMVD_ADDR_SRC_CTRL2   8'h0d
`define PMVD_ADDR_PORT3_MODE  8'hf7
`define PMVD_ADDR_IRQ         8'hfa
`define PMVD_ADDR_INT_MASK    8'hfb

// stop_recovery_ctrl fields
`define PMVD_SRC_PRESCALE     0
`define PMVD_SRC_SEL_LSB      2
`define PMVD_SRC_SEL_MSB      4
`define PMVD_SRC_POR_EN       5
`define PMVD_SRC_WMASK        8'h3d
`define PMVD_SRC_RESET        8'h20

// stop_recovery_ctrl_two fields
`define PMVD_SRC2_LEVEL       6
`define PMVD_SRC2_RESET       1'h0

// supply_voltage_detect fields
`define PMVD_VDET_EN          0
`define PMVD_VDET_LOW         1
`define PMVD_VDET_HIGH        2

// Interrupt request, mask and port 3 mode fields
`define PMVD_IRQ_SUPPLY       5
`define PMVD_MASK_SUPPLY      5
`define PMVD_PORT3_ANALOG     1

// Restart address after leaving STOP
`define PMVD_RESTART_VEC    16'h000c

// Prescaler terminal count for divide-by-16
`define PMVD_DIV_LAST       4'hf

// Timing
`define PMVD_POR_TIME_NS    2500000
`define PMVD_CLK_PERIOD_NS  20

`endif

// >>> design/pmvd_pkg.sv
// Purpose: Types shared by the power/voltage block
// Assumes: Constants come from pmvd_regs.svh
// Notes:   One-hot power states
package pmvd_pkg;

  // Power state, one-hot
  typedef enum logic [3:0] {
    PMVD_ST_HOLD = 4'h1,
    PMVD_ST_RUN  = 4'h2,
    PMVD_ST_HALT = 4'h4,
    PMVD_ST_STOP = 4'h8
  } pmvd_state_t;

  // Register write port from the core
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmvd_reg_req_t;

  // Supply monitor inputs
  typedef struct packed {
    logic ok;
    logic above_high;
    logic below_low;
  } pmvd_supply_t;

endpackage

// >>> design/pmvd_por_timer.sv
// Purpose: One-shot reset delay timer
// Assumes: Single clock, start is a one-cycle pulse
// Notes:   Busy lasts exactly CYCLES clocks after the start; a new start reloads
`timescale 1ns/100ps
`default_nettype none
`include "pmvd_regs.svh"

module pmvd_por_timer #(
  parameter int CYCLES = (`PMVD_POR_TIME_NS + `PMVD_CLK_PERIOD_NS - 1) / `PMVD_CLK_PERIOD_NS
) (
  input  wire logic ref_clk_in,
  input  wire logic srst_in,
  input  wire logic start_in,
  output logic      busy_out
);

  logic [16:0] count_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Down counter, reloaded on every trigger
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      count_reg <= 17'h00000;
      busy_out  <= 1'b0;
    end else if (start_in) begin
      count_reg <= 17'(CYCLES - 1);
      busy_out  <= 1'b1;
    end else if (busy_out) begin
      if (count_reg == 17'h00000) begin
        busy_out <= 1'b0;
      end else begin
        count_reg <= count_reg - 17'h00001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_por_load_start: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    start_in |=> busy_out && count_reg == 17'(CYCLES - 1))
    else $error("reset timer did not load on trigger");

  a_por_min_hold: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    busy_out && count_reg != 17'h00000 |=> busy_out && (start_in || count_reg == $past(count_reg) - 17'h00001)
      || $past(start_in))
    else $error("reset timer ended early");

endmodule

`default_nettype wire

// >>> design/pmvd_top.sv
// Purpose: Power modes, reset delay, stop recovery and supply voltage detection
// Assumes: Core writes registers by number; reads return one cycle later
// Notes:   All clock gating is expressed as enable pulses on ref_clk_in
`timescale 1ns/100ps
`default_nettype none
`include "pmvd_regs.svh"

module pmvd_top #(
  parameter int POR_CYCLES = (`PMVD_POR_TIME_NS + `PMVD_CLK_PERIOD_NS - 1) / `PMVD_CLK_PERIOD_NS
) (
  input  wire logic                   ref_clk_in,
  input  wire logic                   srst_in,
  input  wire pmvd_pkg::pmvd_reg_req_t reg_req_in,
  input  wire pmvd_pkg::pmvd_supply_t  supply_in,
  input  wire logic                   watchdog_timer_timeout_in,
  input  wire logic                   halt_req_in,
  input  wire logic                   stop_req_in,
  input  wire logic                   int_taken_in,
  input  wire logic [7:0]             wake_src_in,
  input  wire logic                   ext_interrupt_pin_in,
  output logic [7:0]                  reg_rdata_out,
  output logic                        cpu_run_out,
  output logic                        cpu_clk_en_out,
  output logic                        timer_interrupt_clock_en_out,
  output logic                        xtal_osc_en_out,
  output logic                        reset_hold_out,
  output logic                        restart_out,
  output logic [15:0]                 restart_addr_out,
  output logic                        supply_warning_request_out,
  output logic                        supply_int_out,
  output logic                        ext_int_source_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  pmvd_pkg::pmvd_state_t state_reg;
  pmvd_pkg::pmvd_state_t state_next;
  logic [7:0]  src_ctrl_reg;
  logic        src_level_reg;
  logic        vdet_en_reg;
  logic        low_flag_reg;
  logic        high_flag_reg;
  logic        supply_req_reg;
  logic        mask_supply_reg;
  logic        port3_analog_reg;
  logic        supply_prev_reg;
  logic [3:0]  div_cnt_reg;
  logic        por_busy;
  logic        por_start;
  logic        supply_rise;
  logic        recovery_hit;
  logic        stop_wake;
  logic        div_tick;
  logic        slow_tick;
  logic        req_clear;

  // Picks one wake source by its 3-bit select
  function automatic logic wake_pick(input logic [7:0] src, input logic [2:0] sel);
    wake_pick = src[sel];
  endfunction

  // True when a write targets the given register
  function automatic logic wr_hit(input pmvd_pkg::pmvd_reg_req_t req, input logic [7:0] addr);
    wr_hit = req.wr && (req.addr == addr);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Event decode
  assign supply_rise  = supply_in.ok && !supply_prev_reg;
  assign recovery_hit = wake_pick(wake_src_in, src_ctrl_reg[`PMVD_SRC_SEL_MSB:`PMVD_SRC_SEL_LSB])
                        == src_level_reg;
  assign stop_wake    = (state_reg == pmvd_pkg::PMVD_ST_STOP) && recovery_hit;
  // Reset delay triggers
  assign por_start    = supply_rise || watchdog_timer_timeout_in
                        || (stop_wake && src_ctrl_reg[`PMVD_SRC_POR_EN]);
  assign div_tick     = (div_cnt_reg == `PMVD_DIV_LAST);
  assign slow_tick    = !src_ctrl_reg[`PMVD_SRC_PRESCALE] || div_tick;
  assign req_clear    = wr_hit(reg_req_in, `PMVD_ADDR_IRQ) && !reg_req_in.wdata[`PMVD_IRQ_SUPPLY];

  ////////////////////////////////////////////////////////////////////////////////
  // Reset delay timer
  pmvd_por_timer #(
    .CYCLES (POR_CYCLES)
  ) u_por_timer (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .start_in   (por_start),
    .busy_out   (por_busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Supply edge memory, starts low so a good supply after reset runs the delay
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      supply_prev_reg <= 1'b0;
    end else begin
      supply_prev_reg <= supply_in.ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power state next value
  always_comb begin
    state_next = state_reg;
    if (!supply_in.ok || por_start) begin
      state_next = pmvd_pkg::PMVD_ST_HOLD;
    end else begin
      unique case (state_reg)
        pmvd_pkg::PMVD_ST_HOLD: begin
          if (!por_busy) begin
            state_next = pmvd_pkg::PMVD_ST_RUN;
          end
        end
        pmvd_pkg::PMVD_ST_RUN: begin
          if (stop_req_in) begin
            state_next = pmvd_pkg::PMVD_ST_STOP;
          end else if (halt_req_in) begin
            state_next = pmvd_pkg::PMVD_ST_HALT;
          end
        end
        pmvd_pkg::PMVD_ST_HALT: begin
          if (int_taken_in) begin
            state_next = pmvd_pkg::PMVD_ST_RUN;
          end
        end
        pmvd_pkg::PMVD_ST_STOP: begin
          if (stop_wake) begin
            state_next = pmvd_pkg::PMVD_ST_RUN;
          end
        end
        default: begin
          state_next = pmvd_pkg::PMVD_ST_HOLD;
        end
      endcase
    end
  end

  // Power state register
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_reg <= pmvd_pkg::PMVD_ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Divide-by-16 prescaler, frozen in STOP
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      div_cnt_reg <= 4'h0;
    end else if (state_reg != pmvd_pkg::PMVD_ST_STOP) begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock enables and run control, all registered
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cpu_run_out                  <= 1'b0;
      cpu_clk_en_out               <= 1'b0;
      timer_interrupt_clock_en_out <= 1'b0;
      xtal_osc_en_out              <= 1'b1;
      reset_hold_out               <= 1'b1;
    end else begin
      cpu_run_out                  <= (state_reg == pmvd_pkg::PMVD_ST_RUN);
      cpu_clk_en_out               <= (state_reg == pmvd_pkg::PMVD_ST_RUN) && slow_tick;
      timer_interrupt_clock_en_out <= ((state_reg == pmvd_pkg::PMVD_ST_RUN)
                                      || (state_reg == pmvd_pkg::PMVD_ST_HALT)) && slow_tick;
      xtal_osc_en_out              <= (state_reg != pmvd_pkg::PMVD_ST_STOP);
      reset_hold_out               <= (state_reg == pmvd_pkg::PMVD_ST_HOLD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Restart request at the fixed address whenever STOP is left
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      restart_out      <= 1'b0;
      restart_addr_out <= `PMVD_RESTART_VEC;
    end else begin
      restart_out      <= (state_reg == pmvd_pkg::PMVD_ST_STOP)
                          && (state_next != pmvd_pkg::PMVD_ST_STOP);
      restart_addr_out <= `PMVD_RESTART_VEC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stop recovery control: prescale, wake source, delay enable
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      src_ctrl_reg <= `PMVD_SRC_RESET;
    end else begin
      if (wr_hit(reg_req_in, `PMVD_ADDR_SRC_CTRL)) begin
        src_ctrl_reg <= reg_req_in.wdata & `PMVD_SRC_WMASK;
      end
      if (stop_wake) begin
        src_ctrl_reg[`PMVD_SRC_PRESCALE] <= 1'b0;
      end
    end
  end

  // Second recovery control: recovery level only, reserved bits dropped
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      src_level_reg <= `PMVD_SRC2_RESET;
    end else if (wr_hit(reg_req_in, `PMVD_ADDR_SRC_CTRL2)) begin
      src_level_reg <= reg_req_in.wdata[`PMVD_SRC2_LEVEL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Detection enable, mask and port 3 mode bits
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      vdet_en_reg      <= 1'b0;
      mask_supply_reg  <= 1'b0;
      port3_analog_reg <= 1'b0;
    end else begin
      if (wr_hit(reg_req_in, `PMVD_ADDR_VDET)) begin
        vdet_en_reg <= reg_req_in.wdata[`PMVD_VDET_EN];
      end
      if (wr_hit(reg_req_in, `PMVD_ADDR_INT_MASK)) begin
        mask_supply_reg <= reg_req_in.wdata[`PMVD_MASK_SUPPLY];
      end
      if (wr_hit(reg_req_in, `PMVD_ADDR_PORT3_MODE)) begin
        port3_analog_reg <= reg_req_in.wdata[`PMVD_PORT3_ANALOG];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Supply flags, sampled every cycle while enabled
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      low_flag_reg  <= 1'b0;
      high_flag_reg <= 1'b0;
    end else begin
      low_flag_reg  <= vdet_en_reg && supply_in.below_low;
      high_flag_reg <= vdet_en_reg && supply_in.above_high;
    end
  end

  // Latched supply request; a new low flag wins over a clear
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      supply_req_reg <= 1'b0;
    end else if (low_flag_reg && vdet_en_reg) begin
      supply_req_reg <= 1'b1;
    end else if (req_clear) begin
      supply_req_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt outputs and external source select
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      supply_warning_request_out <= 1'b0;
      supply_int_out             <= 1'b0;
      ext_int_source_out         <= 1'b0;
    end else begin
      supply_warning_request_out <= supply_req_reg;
      supply_int_out             <= supply_req_reg && mask_supply_reg;
      ext_int_source_out         <= port3_analog_reg ? recovery_hit : ext_interrupt_pin_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read port, one cycle latency, unmapped reads zero
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      unique case (reg_req_in.addr)
        `PMVD_ADDR_SRC_CTRL:   reg_rdata_out <= src_ctrl_reg;
        `PMVD_ADDR_VDET:       reg_rdata_out <= {5'h00, high_flag_reg, low_flag_reg, vdet_en_reg};
        `PMVD_ADDR_IRQ:        reg_rdata_out <= {2'h0, supply_req_reg, 5'h00};
        `PMVD_ADDR_INT_MASK:   reg_rdata_out <= {2'h0, mask_supply_reg, 5'h00};
        `PMVD_ADDR_PORT3_MODE: reg_rdata_out <= {6'h00, port3_analog_reg, 1'b0};
        default:               reg_rdata_out <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_quiet;
    supply_in.ok && !supply_rise && !watchdog_timer_timeout_in;
  endsequence

  sequence s_stop_wake;
    s_quiet ##0 stop_wake;
  endsequence

  a_halt_clk_gate: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    state_reg == pmvd_pkg::PMVD_ST_HALT |=> !cpu_clk_en_out && xtal_osc_en_out && !cpu_run_out)
    else $error("HALT did not gate the CPU clock");

  a_halt_exit_int: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    s_quiet ##0 (state_reg == pmvd_pkg::PMVD_ST_HALT) |->
      (state_next == pmvd_pkg::PMVD_ST_RUN) == int_taken_in)
    else $error("HALT left without a taken interrupt");

  a_stop_osc_off: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    state_reg == pmvd_pkg::PMVD_ST_STOP |=> !xtal_osc_en_out && !timer_interrupt_clock_en_out)
    else $error("STOP left the oscillator running");

  a_stop_restart: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    s_stop_wake |=> restart_out && restart_addr_out == `PMVD_RESTART_VEC ##1 !restart_out)
    else $error("STOP exit gave no restart pulse");

  a_stop_por_trig: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    s_stop_wake ##0 src_ctrl_reg[`PMVD_SRC_POR_EN] |=> state_reg == pmvd_pkg::PMVD_ST_HOLD && por_busy)
    else $error("enabled stop recovery did not run the delay");

  a_stop_por_bypass: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    s_stop_wake ##0 !src_ctrl_reg[`PMVD_SRC_POR_EN] |=> state_reg == pmvd_pkg::PMVD_ST_RUN)
    else $error("bypassed stop recovery did not resume");

  a_prescale_clear: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    stop_wake |=> !src_ctrl_reg[`PMVD_SRC_PRESCALE])
    else $error("stop recovery kept the prescaler");

  a_prescale_rate: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    cpu_clk_en_out && $past(src_ctrl_reg[`PMVD_SRC_PRESCALE]) && src_ctrl_reg[`PMVD_SRC_PRESCALE]
      |=> !cpu_clk_en_out)
    else $error("divided clock enable ran too fast");

  a_hold_no_run: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    por_busy |=> state_reg == pmvd_pkg::PMVD_ST_HOLD)
    else $error("execution ran during the reset delay");

  a_flags_disabled: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !vdet_en_reg |=> !low_flag_reg && !high_flag_reg)
    else $error("supply flag set while detection off");

  a_req_latch: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    supply_req_reg && !req_clear |=> supply_req_reg)
    else $error("supply request dropped without a clear");

  a_req_set: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    low_flag_reg && vdet_en_reg |=> supply_req_reg ##1 supply_warning_request_out)
    else $error("low supply flag raised no request");

  a_int_masked: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !mask_supply_reg |=> !supply_int_out)
    else $error("masked supply interrupt was raised");

  a_ext_source: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !port3_analog_reg |=> ext_int_source_out == $past(ext_interrupt_pin_in))
    else $error("digital mode did not pass the pin");

endmodule

`default_nettype wire

// >>> design/pmvd_unused_guard.sv
// Purpose: Reserved slot, holds no logic
// Assumes: None
// Notes:   None

// >>> testbench/pmvd_testbench.sv
// Purpose: Self-checking bench for the power mode and supply detect block
// Assumes: Reset delay shortened to 20 cycles; inputs change on the falling edge
// Notes:   Expected values come from the register map and power state rules
`timescale 1ns/100ps
`default_nettype none

module testbench;
  localparam int POR = 20;
  logic                    clk;
  logic                    srst;
  pmvd_pkg::pmvd_reg_req_t req;
  pmvd_pkg::pmvd_supply_t  sup;
  logic                    wdog, halt, stop, itk, pin;
  logic [7:0]              wake;
  logic [7:0]              rdata;
  logic                    run, cen, ten, xen, hold, rst_p, wreq, wint, ext;
  logic [15:0]             raddr;
  int                      n_fail;
  int                      checks;
  int                      n, a, b;

  pmvd_top #(.POR_CYCLES(POR)) u_dut (
    .ref_clk_in                   (clk),
    .srst_in                      (srst),
    .reg_req_in                   (req),
    .supply_in                    (sup),
    .watchdog_timer_timeout_in    (wdog),
    .halt_req_in                  (halt),
    .stop_req_in                  (stop),
    .int_taken_in                 (itk),
    .wake_src_in                  (wake),
    .ext_interrupt_pin_in         (pin),
    .reg_rdata_out                (rdata),
    .cpu_run_out                  (run),
    .cpu_clk_en_out               (cen),
    .timer_interrupt_clock_en_out (ten),
    .xtal_osc_en_out              (xen),
    .reset_hold_out               (hold),
    .restart_out                  (rst_p),
    .restart_addr_out             (raddr),
    .supply_warning_request_out   (wreq),
    .supply_int_out               (wint),
    .ext_int_source_out           (ext)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare, count and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Register write, one cycle wide, gap before the next
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, addr: ad, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // Read data shows one edge after the address
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(negedge clk);
    req.addr = ad;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  // Cycles until execution runs again, bounded
  task automatic wait_run(output int k);
    k = 0;
    while (run !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
  endtask

  // Count clock enable pulses over a window
  task automatic count_en(input int k, output int cc, output int tc);
    cc = 0;
    tc = 0;
    repeat (k) begin
      tick(1);
      cc += (cen === 1'b1);
      tc += (ten === 1'b1);
    end
  endtask

  task automatic pulse_halt_stop(input logic s);
    tick(1); // Quiet slot stands in for the no-operation opcode
    if (s) stop = 1'b1;
    else halt = 1'b1;
    tick(1);
    stop = 1'b0;
    halt = 1'b0;
    tick(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    req = '0;
    sup = '{ok: 1'b1, above_high: 1'b0, below_low: 1'b0};
    {wdog, halt, stop, itk, pin} = 5'h00;
    wake = 8'h00;
    n_fail = 0;
    checks = 0;
    void'($urandom(32'h7d2fcf06));
    repeat (12) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    chk(hold, 1'b1);
    wait_run(n);
    chk(n >= POR && n < POR + 10, 1'b1);
    // Register map, unmapped and write-only places
    rd(8'h0b, 8'h20);
    for (int i = 0; i < 4; i++) begin
      n = $urandom_range(10, 0);
      wr(n[7:0], 8'($urandom));
      rd(n[7:0], 8'h00);
    end
    wr(8'h0d, 8'h40);
    rd(8'h0d, 8'h00);
    // Supply detect flags, latched request and mask
    sup.below_low = 1'b1;
    wr(8'h0c, 8'h07);
    tick(5); // No port mode writes while the low flag is watched
    rd(8'h0c, 8'h03);
    chk(wreq, 1'b1);
    chk(wint, 1'b0);
    wr(8'hfb, 8'h20);
    tick(2);
    chk(wint, 1'b1);
    sup = '{ok: 1'b1, above_high: 1'b1, below_low: 1'b0};
    tick(3);
    rd(8'h0c, 8'h05);
    chk(wreq, 1'b1);
    wr(8'hfa, 8'h00);
    tick(3);
    chk(wreq, 1'b0);
    wr(8'h0c, 8'h00);
    tick(2);
    rd(8'h0c, 8'h00);
    sup.below_low = 1'b1;
    tick(4);
    chk(wreq, 1'b0);
    // Mask already set, so enabling detection under low supply interrupts at once
    wr(8'h0c, 8'h01);
    tick(4);
    chk(wint, 1'b1);
    wr(8'h0c, 8'h00);
    sup.below_low = 1'b0;
    wr(8'hfa, 8'h00);
    sup = '{ok: 1'b1, above_high: 1'b0, below_low: 1'b0};
    // HALT keeps oscillator and timer clock, ends on a taken interrupt
    pulse_halt_stop(1'b0);
    count_en(16, a, b);
    chk(16'(a), 16'h0000);
    chk(16'(b), 16'h0010);
    chk(xen, 1'b1);
    tick(1);
    itk = 1'b1;
    tick(1);
    itk = 1'b0;
    tick(2);
    chk(run, 1'b1);
    // Divide-by-16 prescaler
    wr(8'h0b, 8'h21);
    tick(3);
    count_en(32, a, b);
    chk(16'(a), 16'h0002);
    chk(16'(b), 16'h0002);
    // STOP with delay bypassed, source 3, level high
    wr(8'h0b, 8'h0d);
    pulse_halt_stop(1'b1);
    chk({xen, cen, ten}, 3'h0);
    wake = 8'hf7;
    tick(4);
    chk(xen, 1'b0);
    wake = 8'h08;
    chk(rst_p, 1'b0);
    tick(1);
    chk({rst_p, run}, 2'h2);
    chk(raddr, 16'h000c);
    tick(1);
    chk({rst_p, run}, 2'h1);
    wake = 8'h00;
    rd(8'h0b, 8'h0c);
    // STOP with the reset delay enabled
    wr(8'h0b, 8'h2c);
    pulse_halt_stop(1'b1);
    chk(xen, 1'b0);
    wake = 8'h08;
    tick(3);
    chk({hold, run}, 2'h2);
    wait_run(n);
    chk(n >= POR - 4 && n < POR + 10, 1'b1);
    // External interrupt source, pin or recovery logic
    for (int i = 0; i < 8; i++) begin
      pin = 1'($urandom);
      wake = 8'($urandom);
      wr(8'hf7, {6'h00, i[0], 1'b0});
      tick(2);
      chk(ext, i[0] ? wake[3] : pin);
    end
    wake = 8'h00;
    // Watchdog timeout and supply fail restart the delay
    tick(1);
    wdog = 1'b1;
    tick(1);
    wdog = 1'b0;
    tick(2);
    chk({hold, run}, 2'h2);
    wait_run(n);
    chk(n >= POR - 4 && n < POR + 10, 1'b1);
    sup.ok = 1'b0;
    tick(3);
    chk(hold, 1'b1);
    sup.ok = 1'b1;
    tick(3);
    chk(hold, 1'b1);
    wait_run(n);
    chk(n >= POR - 4 && n < POR + 10, 1'b1);
    tally_and_finish();
  end
endmodule

`default_nettype wire
